// file: hw/tcr_limit_store.sv
// Trip limit byte store with a registered byte-wide read port.
`timescale 1ns/1ps
module tcr_limit_store (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire logic [1:0] index_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out,
    output logic [15:0] limit_high_out,
    output logic [15:0] limit_low_out
);
    import tcr_pkg::*;

    logic [7:0] mem [4];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem[0] <= THIGH_RESET[7:0];
            mem[1] <= THIGH_RESET[15:8];
            mem[2] <= TLOW_RESET[7:0];
            mem[3] <= TLOW_RESET[15:8];
        end else if (wr_en_in) begin
            mem[index_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= mem[index_in];
        end
    end

    assign limit_high_out = {mem[1], mem[0]};
    assign limit_low_out = {mem[3], mem[2]};

endmodule

// file: hw/tcr_pkg.sv
// Constants, types and shared functions of the temperature conversion readout.
package tcr_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [6:0] ADDR_CONFIG = 7'h00;
    localparam logic [6:0] ADDR_TEMP_LO = 7'h01;
    localparam logic [6:0] ADDR_TEMP_HI = 7'h02;
    localparam logic [6:0] ADDR_LIMIT_FIRST = 7'h03;
    localparam logic [6:0] ADDR_LIMIT_LAST = 7'h06;
    localparam int ADDR_WRITE_BIT = 7;

    // ************************************************************
    // Configuration fields and reset values
    // ************************************************************
    localparam int CFG_SD_BIT = 0;
    localparam int CFG_RES_LO_BIT = 1;
    localparam int CFG_RES_HI_BIT = 2;
    localparam int CFG_TM_BIT = 3;
    localparam int CFG_ONESHOT_BIT = 4;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] THIGH_RESET = 16'h5000;
    localparam logic [15:0] TLOW_RESET = 16'h4B00;

    // ************************************************************
    // Resolution codes and timing
    // ************************************************************
    localparam logic [1:0] RES_9BIT = 2'h0;
    localparam logic [1:0] RES_10BIT = 2'h1;
    localparam logic [1:0] RES_11BIT = 2'h2;
    localparam logic [1:0] RES_12BIT = 2'h3;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int CONV_TIME_9BIT_MS = 25;
    localparam int CONV_CYCLES_9BIT = CONV_TIME_9BIT_MS * CLK_FREQ_KHZ;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [0:0] {
        CONV_IDLE,
        CONV_RUN
    } tcr_conv_state_t;

    // Keeps the sign and the top magnitude bits, as many bits in all as the resolution selects.
    function automatic logic [15:0] tcr_res_mask(input logic [1:0] res);
        logic [15:0] mask;
        mask = 16'hFF80;
        if (res == RES_10BIT) begin
            mask = 16'hFFC0;
        end else if (res == RES_11BIT) begin
            mask = 16'hFFE0;
        end else if (res == RES_12BIT) begin
            mask = 16'hFFF0;
        end
        return mask;
    endfunction

endpackage

// file: hw/tcr_readout.sv
// Temperature conversion control, result register and serial readout.
`timescale 1ns/1ps
module tcr_readout #(
    parameter int CONV_BASE_CYCLES = tcr_pkg::CONV_CYCLES_9BIT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic transfer_select_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic interface_select_in,
    input wire logic [15:0] sensor_temp_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic thermal_alarm_out,
    output logic thermal_alarm_oe_out,
    output logic [7:0] config_out
);
    import tcr_pkg::*;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [3:0] pins_sync;
    logic sel_active;
    logic sclk_s;
    logic sdi_s;
    logic spi_mode;
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;

    tcr_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({interface_select_in, sdi_in, sclk_in, transfer_select_in}),
        .sync_out(pins_sync)
    );

    assign sel_active = pins_sync[0];
    assign sclk_s = pins_sync[1];
    assign sdi_s = pins_sync[2];
    assign spi_mode = pins_sync[3];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;

    // ************************************************************
    // Serial receive and address phase
    // ************************************************************
    logic [2:0] rx_cnt;
    logic [7:0] rx_shift;
    logic [7:0] next_rx;
    logic have_addr;
    logic is_write;
    logic [6:0] addr;
    logic byte_done;
    logic wr_pulse;
    logic rd_pulse;

    always_comb begin
        if (spi_mode) begin
            next_rx = {rx_shift[6:0], sdi_s};
        end else begin
            next_rx = {sdi_s, rx_shift[7:1]};
        end
    end

    assign byte_done = sel_active & sclk_rise & (rx_cnt == BIT_LAST);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_cnt <= 3'h0;
            rx_shift <= 8'h00;
            have_addr <= 1'b0;
            is_write <= 1'b0;
            addr <= 7'h00;
        end else if (!sel_active) begin
            rx_cnt <= 3'h0;
            have_addr <= 1'b0;
            is_write <= 1'b0;
        end else if (sclk_rise) begin
            rx_shift <= next_rx;
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == BIT_LAST) begin
                if (!have_addr) begin
                    have_addr <= 1'b1;
                    is_write <= next_rx[ADDR_WRITE_BIT];
                    addr <= next_rx[6:0];
                end else begin
                    addr <= addr + 7'h1;
                end
            end
        end
    end

    assign wr_pulse = byte_done & have_addr & is_write;
    assign rd_pulse = byte_done & ~have_addr & ~next_rx[ADDR_WRITE_BIT];

    // ************************************************************
    // Register read mux and limit store
    // ************************************************************
    logic [7:0] cfg;
    logic [15:0] temp_reg;
    logic [7:0] rd_byte;
    logic [7:0] limit_rd;
    logic [15:0] limit_high;
    logic [15:0] limit_low;
    logic limit_sel;
    logic [6:0] limit_offs;

    assign limit_sel = (addr >= ADDR_LIMIT_FIRST) && (addr <= ADDR_LIMIT_LAST);
    assign limit_offs = addr - ADDR_LIMIT_FIRST;

    tcr_limit_store u_limits (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(wr_pulse & limit_sel),
        .index_in(limit_offs[1:0]),
        .wr_data_in(next_rx),
        .rd_data_out(limit_rd),
        .limit_high_out(limit_high),
        .limit_low_out(limit_low)
    );

    always_comb begin
        if (addr == ADDR_CONFIG) begin
            rd_byte = cfg;
        end else if (addr == ADDR_TEMP_LO) begin
            rd_byte = temp_reg[7:0];
        end else if (addr == ADDR_TEMP_HI) begin
            rd_byte = temp_reg[15:8];
        end else if (limit_sel) begin
            rd_byte = limit_rd;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ************************************************************
    // Serial transmit
    // ************************************************************
    logic [2:0] tx_cnt;
    logic [7:0] tx_shift;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_cnt <= 3'h0;
            tx_shift <= 8'h00;
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else if (!sel_active || !have_addr || is_write) begin
            tx_cnt <= 3'h0;
            sdo_oe_out <= 1'b0;
        end else if (sclk_fall) begin
            tx_cnt <= tx_cnt + 3'h1;
            sdo_oe_out <= 1'b1;
            if (tx_cnt == 3'h0) begin
                if (spi_mode) begin
                    sdo_out <= rd_byte[7];
                    tx_shift <= {rd_byte[6:0], 1'b0};
                end else begin
                    sdo_out <= rd_byte[0];
                    tx_shift <= {1'b0, rd_byte[7:1]};
                end
            end else if (spi_mode) begin
                sdo_out <= tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
            end else begin
                sdo_out <= tx_shift[0];
                tx_shift <= {1'b0, tx_shift[7:1]};
            end
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    logic conv_done;
    logic single_mode;
    logic cfg_wr;

    assign cfg_wr = wr_pulse & (addr == ADDR_CONFIG);
    assign single_mode = cfg[CFG_SD_BIT];

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= next_rx & CFG_WRITE_MASK;
        end else if (conv_done && single_mode) begin
            cfg[CFG_ONESHOT_BIT] <= 1'b0;
        end
    end

    assign config_out = cfg;

    // ************************************************************
    // Conversion control
    // ************************************************************
    tcr_conv_state_t state;
    logic [31:0] conv_cnt;
    logic [31:0] conv_limit;
    logic [1:0] run_res;
    logic [15:0] conv_value;

    assign conv_limit = 32'(CONV_BASE_CYCLES) << run_res;
    assign conv_done = (state == CONV_RUN) && (conv_cnt == conv_limit - 32'h1);

    assign conv_value = sensor_temp_in & tcr_res_mask(run_res);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= CONV_IDLE;
            conv_cnt <= 32'h0;
            run_res <= RES_9BIT;
        end else begin
            case (state)
                CONV_IDLE: begin
                    conv_cnt <= 32'h0;
                    if (!single_mode || cfg[CFG_ONESHOT_BIT]) begin
                        state <= CONV_RUN;
                        run_res <= cfg[CFG_RES_HI_BIT:CFG_RES_LO_BIT];
                    end
                end
                CONV_RUN: begin
                    if (conv_done) begin
                        conv_cnt <= 32'h0;
                        run_res <= cfg[CFG_RES_HI_BIT:CFG_RES_LO_BIT];
                        if (single_mode) begin
                            state <= CONV_IDLE;
                        end
                    end else if (single_mode && !cfg[CFG_ONESHOT_BIT]) begin
                        state <= CONV_IDLE;
                    end else begin
                        conv_cnt <= conv_cnt + 32'h1;
                    end
                end
                default: begin
                    state <= CONV_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Result register
    // ************************************************************
    logic pending;
    logic [15:0] pending_value;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pending <= 1'b0;
            pending_value <= TEMP_RESET;
            temp_reg <= TEMP_RESET;
        end else if (conv_done) begin
            // two's complement code kept as is
            if (!sel_active) begin
                temp_reg <= conv_value;
                pending <= 1'b0;
            end else begin
                pending_value <= conv_value;
                pending <= 1'b1;
            end
        end else if (pending && !sel_active) begin
            temp_reg <= pending_value;
            pending <= 1'b0;
        end
    end

    // ************************************************************
    // Thermal alarm
    // ************************************************************
    logic alarm;
    logic expect_low;
    logic above_high;
    logic below_low;
    logic shutdown_wr;

    assign above_high = $signed(conv_value) > $signed(limit_high & tcr_res_mask(run_res));
    assign below_low = $signed(conv_value) < $signed(limit_low & tcr_res_mask(run_res));
    assign shutdown_wr = cfg_wr & next_rx[CFG_SD_BIT] & ~single_mode;

    // Interrupt mode clears on any read, but a crossing in the same cycle still wins.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            alarm <= 1'b0;
            expect_low <= 1'b0;
        end else if (!cfg[CFG_TM_BIT]) begin
            expect_low <= 1'b0;
            if (conv_done && above_high) begin
                alarm <= 1'b1;
            end else if (conv_done && below_low) begin
                alarm <= 1'b0;
            end
        end else begin
            if (conv_done && !expect_low && above_high) begin
                alarm <= 1'b1;
                expect_low <= 1'b1;
            end else if (conv_done && expect_low && below_low) begin
                alarm <= 1'b1;
                expect_low <= 1'b0;
            end else if (rd_pulse || shutdown_wr) begin
                alarm <= 1'b0;
            end
        end
    end

    assign thermal_alarm_out = 1'b0;
    assign thermal_alarm_oe_out = alarm;

endmodule

// file: hw/tcr_sync2.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module tcr_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import tcr_pkg::*;

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// file: verif/tcr_host_model.sv
// Host serial controller model for both link modes.
`timescale 1ns/1ps
module tcr_host_model (
    input wire logic spi_mode_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic select_out,
    output logic sclk_out,
    output logic line_out,
    output logic rd_done_out,
    output logic [7:0] rd_byte_out
);
    logic host_oe = 1'b0;
    logic host_bit = 1'b0;
    logic noise = 1'b0;
    initial begin
        select_out = 1'b0;
        sclk_out = 1'b0;
        rd_done_out = 1'b0;
        rd_byte_out = 8'h00;
    end
    // A released line toggles so a stale level can never pass for data.
    always #5 noise = ~noise;
    assign line_out = (!spi_mode_in && sdo_oe_in) ? sdo_in : (host_oe ? host_bit : noise);
    task automatic frame(input logic [7:0] addr, input int nbytes, input logic [15:0] wdata);
        logic [7:0] sh;
        logic [7:0] got;
        // select held over the whole frame
        select_out = 1'b1;
        #400;
        for (int b = 0; b <= nbytes; b++) begin
            sh = (b == 0) ? addr : ((b == 1) ? wdata[7:0] : wdata[15:8]);
            // host lets go of the line for read bits
            host_oe = (b == 0) || addr[7];
            for (int i = 0; i < 8; i++) begin
                host_bit = spi_mode_in ? sh[7 - i] : sh[i];
                #32 sclk_out = 1'b1;
                got[spi_mode_in ? 7 - i : i] = spi_mode_in ? sdo_in : line_out;
                #32 sclk_out = 1'b0;
            end
            if (b > 0 && !addr[7]) begin
                rd_byte_out = got;
                rd_done_out = 1'b1;
                #1 rd_done_out = 1'b0;
            end
        end
        host_oe = 1'b0;
        #100 select_out = 1'b0;
        #400;
    endtask
endmodule

// file: verif/tcr_readout_asserts.sv
// Port-level checks on the readout block.
`timescale 1ns/1ps
module tcr_readout_asserts #(
    parameter int CONV_BASE_CYCLES = tcr_pkg::CONV_CYCLES_9BIT
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic transfer_select_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic interface_select_in,
    input wire logic [15:0] sensor_temp_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic thermal_alarm_out,
    input wire logic thermal_alarm_oe_out,
    input wire logic [7:0] config_out
);
    import tcr_pkg::*;
    // Slack covers the cycle from the write to the start of the conversion.
    localparam int ONESHOT_LIMIT = 8 * CONV_BASE_CYCLES + 1000;
    logic [9:0] sclk_hist;
    logic fall_seen;
    int oneshot_cycles;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ****************************************
    // Helper history of the raw link clock
    // ****************************************
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_hist <= '0;
            oneshot_cycles <= 0;
        end else begin
            sclk_hist <= {sclk_hist[8:0], sclk_in};
            oneshot_cycles <= config_out[4] ? oneshot_cycles + 1 : 0;
        end
    end
    assign fall_seen = |(sclk_hist[9:1] & ~sclk_hist[8:0]);
    property p_quiet_oe;
        !transfer_select_in [*6] |-> !sdo_oe_out;
    endproperty
    a_quiet_oe: assert property (p_quiet_oe) else $error("line driven without select");
    property p_oe_release;
        sdo_oe_out && !transfer_select_in |-> ##[1:5] !sdo_oe_out;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("line not released");
    property p_sdo_on_fall;
        !$stable(sdo_out) |-> fall_seen;
    endproperty
    a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data out moved without clock fall");
    property p_oe_rise;
        $rose(sdo_oe_out) |-> fall_seen && transfer_select_in;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive began off a clock fall");
    property p_alarm_pin;
        thermal_alarm_out == 1'b0;
    endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin drives high");
    property p_reset_state;
        $past(sys_rst_in) |-> config_out == 8'h01;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("not shutdown at 9 bits after reset");
    property p_cfg_no_frame;
        !transfer_select_in [*6] |=> $stable(config_out) || config_out == ($past(config_out) & 8'hEF);
    endproperty
    a_cfg_no_frame: assert property (p_cfg_no_frame) else $error("mode changed outside a frame");
    property p_oneshot_bound;
        oneshot_cycles < ONESHOT_LIMIT;
    endproperty
    a_oneshot_bound: assert property (p_oneshot_bound) else $error("single conversion never ends");
    c_read: cover property ($rose(sdo_oe_out));
    c_oneshot: cover property ($fell(config_out[4]));
    c_cont: cover property ($fell(config_out[0]));
endmodule
bind tcr_readout tcr_readout_asserts #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) u_readout_asserts (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .transfer_select_in(transfer_select_in), .sclk_in(sclk_in),
    .sdi_in(sdi_in), .interface_select_in(interface_select_in), .sensor_temp_in(sensor_temp_in),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .thermal_alarm_out(thermal_alarm_out),
    .thermal_alarm_oe_out(thermal_alarm_oe_out), .config_out(config_out)
);

// file: verif/tcr_readout_bench.sv
// Self-checking bench for the readout block.
`timescale 1ns/1ps
module tcr_readout_bench;
    import tcr_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic spi_mode = 1'b1;
    logic [15:0] sensor = 16'h0000;
    logic [15:0] expv, prev;
    logic [15:0] tbl[6] = '{16'h7D00, 16'h0080, 16'hFF80, 16'hC900, 16'hF5E0, 16'hE6F0};
    logic [7:0] expq[$];
    logic [7:0] cfg, rd_byte;
    logic sel, sclk, line, sdo, sdo_oe, rd_done, alarm_oe;
    int mismatches = 0;
    int check_count = 0;
    always #2.5 clk_in = ~clk_in;
    tcr_readout #(.CONV_BASE_CYCLES(20)) dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .transfer_select_in(sel), .sclk_in(sclk), .sdi_in(line),
        .interface_select_in(spi_mode), .sensor_temp_in(sensor), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
        .thermal_alarm_out(), .thermal_alarm_oe_out(alarm_oe), .config_out(cfg)
    );
    tcr_host_model host (
        .spi_mode_in(spi_mode), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .select_out(sel), .sclk_out(sclk),
        .line_out(line), .rd_done_out(rd_done), .rd_byte_out(rd_byte)
    );
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic fail(input string msg);
        mismatches++;
        $display("FAIL %0t %s", $time, msg);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input int n, input logic [15:0] e);
        expq.push_back(e[7:0]);
        if (n > 1) expq.push_back(e[15:8]);
        host.frame({1'b0, a}, n, 16'h0000);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.frame({1'b1, a}, 1, {8'h00, d});
    endtask
    task automatic conclude;
        if (expq.size() != 0) fail("read bytes missing");
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge rd_done) begin
        check_count++;
        if (expq.size() == 0 || rd_byte !== expq[0]) fail("read byte differs");
        if (expq.size() != 0) void'(expq.pop_front());
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hC5546E10));
        tick(10);
        sys_rst_in = 1'b0;
        tick(3);
        sensor = 16'h1910;
        tick(300);
        rd(ADDR_CONFIG, 1, 16'h0001);
        rd(ADDR_TEMP_LO, 2, TEMP_RESET);
        rd(7'h06, 2, {8'h00, TLOW_RESET[15:8]});
        $display("reset test done");
        prev = TEMP_RESET;
        for (int r = 0; r < 4; r++) begin
            tick(1);
            spi_mode = r[0];
            sensor = 16'($urandom());
            expv = sensor & (16'hFFFF << (7 - r));
            wr(ADDR_CONFIG, {3'h0, 1'b1, 1'b0, r[1:0], 1'b1});
            // Only the 12-bit conversion outlasts the gap to this frame.
            rd(ADDR_TEMP_LO, 2, (r == 3) ? prev : expv);
            for (int i = 0; i < 400 && cfg[4] === 1'b1; i++) tick(1);
            if (cfg[4] !== 1'b0) begin
                fail("single conversion hung");
                conclude();
            end
            rd(ADDR_TEMP_LO, 2, expv);
            rd(ADDR_CONFIG, 1, {13'h0000, r[1:0], 1'b1});
            tick(1);
            sensor = ~sensor;
            tick(400);
            rd(ADDR_TEMP_LO, 2, expv);
            prev = expv;
        end
        $display("single conversion test done");
        wr(ADDR_CONFIG, 8'h06);
        foreach (tbl[i]) begin
            tick(1);
            spi_mode = i[0];
            sensor = tbl[i];
            tick(400);
            rd(ADDR_TEMP_LO, 2, tbl[i]);
            // Only the first table entry lies above the high limit; the rest fall below the low one.
            check_count++;
            if (alarm_oe !== (i == 0)) fail("alarm level differs");
        end
        $display("continuous test done");
        wr(ADDR_TEMP_LO, 8'hAA);
        wr(ADDR_TEMP_HI, 8'h55);
        rd(ADDR_TEMP_LO, 2, tbl[5]);
        $display("read-only test done");
        conclude();
    end
endmodule
